// ==== rss_pkg.sv ====
// shared constants and operation codes for the rotate/subtract/skip datapath
package rss_pkg;
   localparam int DATA_W = 8;
   localparam int MSB = 7;
   localparam int LSB = 0;
   localparam int BITSEL_W = 3;
   localparam logic [7:0] ALL_ONES = 8'hff;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] ONE_BYTE = 8'h01;
   localparam int NIB_MSB = 3;
   localparam logic [1:0] SKIP_CYCLES = 2'h2;

   typedef enum logic [3:0] {
      RSS_OP_NONE = 4'h0,
      RSS_OP_ROTATE_LEFT_MEM = 4'h1,
      RSS_OP_ROTATE_LEFT_THRU_CARRY_MEM = 4'h2,
      RSS_OP_ROTATE_RIGHT_MEM = 4'h3,
      RSS_OP_ROTATE_RIGHT_VIA_FLAG_MEM = 4'h4,
      RSS_OP_MINUS_MEM_BORROW = 4'h5,
      RSS_OP_MINUS_MEM = 4'h6,
      RSS_OP_DEC_SKIP_NIL = 4'h7,
      RSS_OP_INC_SKIP_NIL = 4'h8,
      RSS_OP_BIT_ONE_SKIP = 4'h9,
      RSS_OP_SET_BYTE = 4'ha,
      RSS_OP_SET_BIT = 4'hb
   } rss_op_type;

   typedef enum logic [1:0] {
      RSS_ST_EXEC = 2'b00,
      RSS_ST_DUMMY = 2'b01
   } rss_state_type;
endpackage : rss_pkg

// ==== rss_res_if.sv ====
// result and flag bundle between the operation decoder and the main datapath
`timescale 1ns/100ps
interface rss_res_if;
   logic [7:0] result;
   logic wr_mem;
   logic wr_acc;
   logic upd_carry;
   logic upd_arith;
   logic carry;
   logic ovf;
   logic zero;
   logic nib_carry;
   logic skip;
   modport prod (output result, wr_mem, wr_acc, upd_carry, upd_arith, carry, ovf, zero, nib_carry, skip);
   modport cons (input result, wr_mem, wr_acc, upd_carry, upd_arith, carry, ovf, zero, nib_carry, skip);
endinterface : rss_res_if

// ==== rss_adder.sv ====
// 8-bit adder producing carry, nibble carry and signed-range overflow
`timescale 1ns/100ps
module rss_adder #(
   parameter int W = 8
) (
   input wire logic [W-1:0] a_i,
   input wire logic [W-1:0] b_i,
   input wire logic cin_i,
   output logic [W-1:0] sum_o,
   output logic cout_o,
   output logic nib_o,
   output logic ovf_o
);
   wire [W:0] full_sum = {1'b0, a_i} + {1'b0, b_i} + {{W{1'b0}}, cin_i};
   wire [4:0] low_sum = {1'b0, a_i[rss_pkg::NIB_MSB:0]} + {1'b0, b_i[rss_pkg::NIB_MSB:0]} + {4'h0, cin_i};
   // overflow: operands share a sign that the result does not
   assign sum_o = full_sum[W-1:0];
   assign cout_o = full_sum[W];
   assign nib_o = low_sum[4];
   assign ovf_o = (a_i[W-1] == b_i[W-1]) && (sum_o[W-1] != a_i[W-1]);
endmodule : rss_adder

// ==== rss_decode.sv ====
// per-operation result, destination and flag selection
`timescale 1ns/100ps
module rss_decode (
   input wire rss_pkg::rss_op_type op_i,
   input wire logic to_acc_i,
   input wire logic [7:0] mem_i,
   input wire logic [7:0] acc_i,
   input wire logic carry_i,
   input wire logic [2:0] bit_sel_i,
   rss_res_if.prod res
);
   logic [7:0] sum;
   logic cout;
   logic nib;
   logic ovf;
   logic [7:0] bit_mask;
   wire sub_cin = (op_i == rss_pkg::RSS_OP_MINUS_MEM) ? 1'b1 : carry_i;
   wire [7:0] dec_val = mem_i - rss_pkg::ONE_BYTE;
   wire [7:0] inc_val = mem_i + rss_pkg::ONE_BYTE;

   rss_adder #(.W(rss_pkg::DATA_W)) u_add (
      .a_i(acc_i),
      .b_i(~mem_i),
      .cin_i(sub_cin),
      .sum_o(sum),
      .cout_o(cout),
      .nib_o(nib),
      .ovf_o(ovf)
   );

   genvar g;
   for (g = 0; g < rss_pkg::DATA_W; g++) begin : g_mask
      assign bit_mask[g] = (bit_sel_i == 3'(g));
   end

   always_comb begin
      res.result = mem_i;
      res.wr_mem = 1'b0;
      res.wr_acc = 1'b0;
      res.upd_carry = 1'b0;
      res.upd_arith = 1'b0;
      res.carry = carry_i;
      res.ovf = ovf;
      res.zero = (sum == rss_pkg::ZERO_BYTE);
      res.nib_carry = nib;
      res.skip = 1'b0;
      unique case (op_i)
         rss_pkg::RSS_OP_ROTATE_LEFT_MEM: begin
            res.result = {mem_i[rss_pkg::MSB-1:0], mem_i[rss_pkg::MSB]};
            res.wr_mem = ~to_acc_i;
            res.wr_acc = to_acc_i;
         end
         rss_pkg::RSS_OP_ROTATE_LEFT_THRU_CARRY_MEM: begin
            res.result = {mem_i[rss_pkg::MSB-1:0], carry_i};
            res.carry = mem_i[rss_pkg::MSB];
            res.upd_carry = 1'b1;
            res.wr_mem = ~to_acc_i;
            res.wr_acc = to_acc_i;
         end
         rss_pkg::RSS_OP_ROTATE_RIGHT_MEM: begin
            res.result = {mem_i[rss_pkg::LSB], mem_i[rss_pkg::MSB:1]};
            res.wr_mem = ~to_acc_i;
            res.wr_acc = to_acc_i;
         end
         rss_pkg::RSS_OP_ROTATE_RIGHT_VIA_FLAG_MEM: begin
            res.result = {carry_i, mem_i[rss_pkg::MSB:1]};
            res.carry = mem_i[rss_pkg::LSB];
            res.upd_carry = 1'b1;
            res.wr_mem = ~to_acc_i;
            res.wr_acc = to_acc_i;
         end
         rss_pkg::RSS_OP_MINUS_MEM_BORROW: begin
            res.result = sum;
            res.carry = cout;
            res.upd_carry = 1'b1;
            res.upd_arith = 1'b1;
            res.wr_mem = ~to_acc_i;
            res.wr_acc = to_acc_i;
         end
         rss_pkg::RSS_OP_MINUS_MEM: begin
            // always lands in the accumulator; memory form is not covered here
            res.result = sum;
            res.carry = cout;
            res.upd_carry = 1'b1;
            res.upd_arith = 1'b1;
            res.wr_acc = 1'b1;
         end
         rss_pkg::RSS_OP_DEC_SKIP_NIL: begin
            res.result = dec_val;
            res.skip = (dec_val == rss_pkg::ZERO_BYTE);
            res.wr_mem = ~to_acc_i;
            res.wr_acc = to_acc_i;
         end
         rss_pkg::RSS_OP_INC_SKIP_NIL: begin
            res.result = inc_val;
            res.skip = (inc_val == rss_pkg::ZERO_BYTE);
            res.wr_mem = ~to_acc_i;
            res.wr_acc = to_acc_i;
         end
         rss_pkg::RSS_OP_BIT_ONE_SKIP: begin
            res.skip = |(mem_i & bit_mask);
         end
         rss_pkg::RSS_OP_SET_BYTE: begin
            res.result = rss_pkg::ALL_ONES;
            res.wr_mem = 1'b1;
         end
         rss_pkg::RSS_OP_SET_BIT: begin
            res.result = mem_i | bit_mask;
            res.wr_mem = 1'b1;
         end
         default: begin
            res.result = mem_i;
         end
      endcase
   end
endmodule : rss_decode

// ==== rss_alu.sv ====
// rotate, subtract, skip and set execution datapath of the 8-bit core
`timescale 1ns/100ps
module rss_alu (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic exec_i,
   input wire rss_pkg::rss_op_type op_i,
   input wire logic to_acc_i,
   input wire logic [7:0] mem_rdata_i,
   input wire logic [7:0] mem_addr_i,
   input wire logic [2:0] bit_sel_i,
   output logic [7:0] acc_o,
   output logic carry_o,
   output logic signed_range_flag_o,
   output logic zero_o,
   output logic nibble_carry_flag_o,
   output logic mem_we_o,
   output logic [7:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   output logic discard_fetch_o,
   output logic busy_o,
   output logic done_o
);
   rss_res_if res ();

   logic [7:0] acc_q, acc_d;
   logic c_q, c_d, ov_q, ov_d, z_q, z_d, ac_q, ac_d;
   logic we_q, discard_q, busy_q, done_q;
   logic [7:0] waddr_q, wdata_q;
   rss_pkg::rss_state_type st_q, st_d;

   rss_decode u_dec (
      .op_i(op_i),
      .to_acc_i(to_acc_i),
      .mem_i(mem_rdata_i),
      .acc_i(acc_q),
      .carry_i(c_q),
      .bit_sel_i(bit_sel_i),
      .res(res)
   );

   // instructions arriving during the dummy cycle are ignored: the sequencer stalls
   wire take = exec_i && (st_q == rss_pkg::RSS_ST_EXEC);
   wire do_skip = take && res.skip;
   assign acc_d = (take && res.wr_acc) ? res.result : acc_q;
   assign c_d = (take && res.upd_carry) ? res.carry : c_q;
   assign ov_d = (take && res.upd_arith) ? res.ovf : ov_q;
   assign z_d = (take && res.upd_arith) ? res.zero : z_q;
   assign ac_d = (take && res.upd_arith) ? res.nib_carry : ac_q;
   assign st_d = do_skip ? rss_pkg::RSS_ST_DUMMY : rss_pkg::RSS_ST_EXEC;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         acc_q <= rss_pkg::ZERO_BYTE;
         {c_q, ov_q, z_q, ac_q} <= 4'h0;
      end else begin
         acc_q <= acc_d;
         {c_q, ov_q, z_q, ac_q} <= {c_d, ov_d, z_d, ac_d};
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st_q <= rss_pkg::RSS_ST_EXEC;
         we_q <= 1'b0;
         waddr_q <= rss_pkg::ZERO_BYTE;
         wdata_q <= rss_pkg::ZERO_BYTE;
         discard_q <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         we_q <= take && res.wr_mem;
         waddr_q <= take ? mem_addr_i : waddr_q;
         wdata_q <= take ? res.result : wdata_q;
         discard_q <= do_skip;
         busy_q <= do_skip;
         done_q <= take;
      end
   end

   assign acc_o = acc_q;
   assign carry_o = c_q;
   assign signed_range_flag_o = ov_q;
   assign zero_o = z_q;
   assign nibble_carry_flag_o = ac_q;
   assign mem_we_o = we_q;
   assign mem_addr_o = waddr_q;
   assign mem_wdata_o = wdata_q;
   assign discard_fetch_o = discard_q;
   assign busy_o = busy_q;
   assign done_o = done_q;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   rot_left_a: assert property (take && op_i == rss_pkg::RSS_OP_ROTATE_LEFT_MEM && !to_acc_i
      |=> mem_we_o && mem_wdata_o == {$past(mem_rdata_i[6:0]), $past(mem_rdata_i[7])})
      else $error("rotate left result wrong");
   acc_rot_a: assert property (take && op_i == rss_pkg::RSS_OP_ROTATE_LEFT_MEM && to_acc_i
      |=> !mem_we_o && acc_o == {$past(mem_rdata_i[6:0]), $past(mem_rdata_i[7])})
      else $error("accumulator rotate left wrong");
   rlc_carry_a: assert property (take && op_i == rss_pkg::RSS_OP_ROTATE_LEFT_THRU_CARRY_MEM
      |=> carry_o == $past(mem_rdata_i[7]) && mem_wdata_o[0] == $past(c_q) && $stable(zero_o))
      else $error("rotate left through carry wrong");
   rot_right_a: assert property (take && op_i == rss_pkg::RSS_OP_ROTATE_RIGHT_MEM
      |=> mem_wdata_o == {$past(mem_rdata_i[0]), $past(mem_rdata_i[7:1])} && $stable(carry_o))
      else $error("rotate right wrong");
   rrc_carry_a: assert property (take && op_i == rss_pkg::RSS_OP_ROTATE_RIGHT_VIA_FLAG_MEM
      |=> carry_o == $past(mem_rdata_i[0]) && mem_wdata_o[7] == $past(c_q))
      else $error("rotate right through carry wrong");
   sub_borrow_a: assert property (take && op_i == rss_pkg::RSS_OP_MINUS_MEM_BORROW && to_acc_i
      |=> acc_o == 8'($past(acc_q) + ~$past(mem_rdata_i) + {7'h0, $past(c_q)}))
      else $error("subtract with borrow wrong");
   sub_mem_a: assert property (take && op_i == rss_pkg::RSS_OP_MINUS_MEM_BORROW && !to_acc_i
      |=> mem_we_o && $stable(acc_o) && zero_o == (mem_wdata_o == 8'h00))
      else $error("borrow subtract to memory wrong");
   sub_plain_a: assert property (take && op_i == rss_pkg::RSS_OP_MINUS_MEM
      |=> acc_o == 8'($past(acc_q) - $past(mem_rdata_i)) && carry_o == ($past(acc_q) >= $past(mem_rdata_i)))
      else $error("plain subtract wrong");
   dec_skip_a: assert property (take && op_i == rss_pkg::RSS_OP_DEC_SKIP_NIL && mem_rdata_i == 8'h01
      |=> discard_fetch_o && $stable(carry_o))
      else $error("decrement skip missed");
   inc_skip_a: assert property (take && op_i == rss_pkg::RSS_OP_INC_SKIP_NIL && to_acc_i
      |=> !mem_we_o && discard_fetch_o == (acc_o == 8'h00))
      else $error("increment skip wrong");
   bit_skip_a: assert property (take && op_i == rss_pkg::RSS_OP_BIT_ONE_SKIP
      |=> discard_fetch_o == $past(mem_rdata_i[bit_sel_i]) && !mem_we_o)
      else $error("bit skip wrong");
   dummy_cycle_a: assert property (discard_fetch_o |-> !take ##1 !discard_fetch_o)
      else $error("dummy cycle missing");
   set_byte_a: assert property (take && op_i == rss_pkg::RSS_OP_SET_BYTE
      |=> mem_we_o && mem_wdata_o == 8'hff && $stable(carry_o))
      else $error("byte set wrong");
   set_bit_a: assert property (take && op_i == rss_pkg::RSS_OP_SET_BIT
      |=> mem_wdata_o == ($past(mem_rdata_i) | (8'h01 << $past(bit_sel_i))))
      else $error("bit set wrong");

   skip_seen_c: cover property (do_skip ##1 discard_fetch_o);
   sub_seen_c: cover property (take && op_i == rss_pkg::RSS_OP_MINUS_MEM_BORROW);
   rot_seen_c: cover property (take && op_i == rss_pkg::RSS_OP_ROTATE_LEFT_THRU_CARRY_MEM);
   bit_set_c: cover property (take && op_i == rss_pkg::RSS_OP_SET_BIT);
endmodule : rss_alu

// ==== rss_mem_model.sv ====
// behavioural data memory that feeds the operand and takes write-backs
`timescale 1ns/100ps
module rss_mem_model (
   input wire logic clk_i,
   input wire logic [7:0] rd_addr_i,
   output logic [7:0] rdata_o,
   input wire logic we_i,
   input wire logic [7:0] wr_addr_i,
   input wire logic [7:0] wr_data_i
);
   logic [7:0] mem [256];
   // read is combinational: the datapath samples its operand in the cycle it is addressed
   assign rdata_o = mem[rd_addr_i];
   always @(posedge clk_i) begin
      if (we_i === 1'h1) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end
endmodule : rss_mem_model

// ==== tb_rss_alu.sv ====
// self-checking bench for the rotate, subtract, skip and set datapath
`timescale 1ns/100ps
module tb_rss_alu;
   typedef struct packed {
      logic [3:0] op;
      logic ta;
      logic [7:0] m;
      logic [2:0] bs;
      logic [7:0] acc;
      logic [3:0] fl;
      logic we;
      logic [7:0] wd;
      logic sk;
   } rss_row_type;
   logic clk_i = 1'h0;
   logic rstn_i = 1'h0;
   logic exec_i = 1'h0;
   rss_pkg::rss_op_type op_i = rss_pkg::RSS_OP_NONE;
   logic to_acc_i = 1'h0;
   logic [7:0] mem_rdata_i;
   logic [7:0] addr = 8'h00;
   logic [2:0] bit_sel_i = 3'h0;
   logic [7:0] acc_o;
   logic carry_o, ovf_o, zero_o, nib_o, mem_we_o, discard_fetch_o, busy_o, done_o;
   logic [7:0] mem_addr_o;
   logic [7:0] mem_wdata_o;
   int n_fail = 0;
   int num_checks = 0;
   rss_row_type r;
   // op codes follow rss_op_type; fl is {range, zero, nibble, carry}; rows chain through acc and flags
   rss_row_type rows [22] = '{
      '{4'h1, 1'h1, 8'h81, 3'h0, 8'h03, 4'h0, 1'h0, 8'h00, 1'h0}, '{4'h1, 1'h0, 8'h81, 3'h0, 8'h03, 4'h0, 1'h1, 8'h03, 1'h0},
      '{4'h2, 1'h1, 8'h80, 3'h0, 8'h00, 4'h1, 1'h0, 8'h00, 1'h0}, '{4'h2, 1'h0, 8'h40, 3'h0, 8'h00, 4'h0, 1'h1, 8'h81, 1'h0},
      '{4'h3, 1'h1, 8'h01, 3'h0, 8'h80, 4'h0, 1'h0, 8'h00, 1'h0}, '{4'h3, 1'h0, 8'h02, 3'h0, 8'h80, 4'h0, 1'h1, 8'h01, 1'h0},
      '{4'h4, 1'h1, 8'h01, 3'h0, 8'h00, 4'h1, 1'h0, 8'h00, 1'h0}, '{4'h4, 1'h0, 8'h02, 3'h0, 8'h00, 4'h0, 1'h1, 8'h81, 1'h0},
      '{4'h1, 1'h1, 8'h28, 3'h0, 8'h50, 4'h0, 1'h0, 8'h00, 1'h0}, '{4'h5, 1'h1, 8'h30, 3'h0, 8'h1f, 4'h1, 1'h0, 8'h00, 1'h0},
      '{4'h5, 1'h0, 8'h1f, 3'h0, 8'h1f, 4'h7, 1'h1, 8'h00, 1'h0}, '{4'h6, 1'h1, 8'h20, 3'h0, 8'hff, 4'h2, 1'h0, 8'h00, 1'h0},
      '{4'h1, 1'h1, 8'h40, 3'h0, 8'h80, 4'h2, 1'h0, 8'h00, 1'h0}, '{4'h6, 1'h1, 8'h01, 3'h0, 8'h7f, 4'h9, 1'h0, 8'h00, 1'h0},
      '{4'h7, 1'h0, 8'h01, 3'h0, 8'h7f, 4'h9, 1'h1, 8'h00, 1'h1}, '{4'h7, 1'h1, 8'h00, 3'h0, 8'hff, 4'h9, 1'h0, 8'h00, 1'h0},
      '{4'h8, 1'h1, 8'hff, 3'h0, 8'h00, 4'h9, 1'h0, 8'h00, 1'h1}, '{4'h8, 1'h0, 8'h7f, 3'h0, 8'h00, 4'h9, 1'h1, 8'h80, 1'h0},
      '{4'h9, 1'h0, 8'h08, 3'h3, 8'h00, 4'h9, 1'h0, 8'h00, 1'h1}, '{4'h9, 1'h0, 8'hf7, 3'h3, 8'h00, 4'h9, 1'h0, 8'h00, 1'h0},
      '{4'ha, 1'h0, 8'h12, 3'h0, 8'h00, 4'h9, 1'h1, 8'hff, 1'h0}, '{4'hb, 1'h0, 8'h40, 3'h7, 8'h00, 4'h9, 1'h1, 8'hc0, 1'h0}};

   rss_alu u_rss_alu (.clk_i(clk_i), .rstn_i(rstn_i), .exec_i(exec_i), .op_i(op_i), .to_acc_i(to_acc_i),
      .mem_rdata_i(mem_rdata_i), .mem_addr_i(addr), .bit_sel_i(bit_sel_i), .acc_o(acc_o), .carry_o(carry_o),
      .signed_range_flag_o(ovf_o), .zero_o(zero_o), .nibble_carry_flag_o(nib_o), .mem_we_o(mem_we_o),
      .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .discard_fetch_o(discard_fetch_o), .busy_o(busy_o),
      .done_o(done_o));
   rss_mem_model u_rss_mem_model (.clk_i(clk_i), .rd_addr_i(addr), .rdata_o(mem_rdata_i), .we_i(mem_we_o),
      .wr_addr_i(mem_addr_o), .wr_data_i(mem_wdata_o));

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict

   initial begin
      forever begin
         #50;
         clk_i = ~clk_i;
      end
   end

   // generous bound: the whole sequence needs well under 100 cycles
   initial begin
      repeat (2000) @(posedge clk_i);
      n_fail++;
      $display("BAD watchdog expired");
      give_verdict();
   end

   initial begin
      repeat (2) @(negedge clk_i);
      rstn_i = 1'h1;
      for (int i = 0; i < 22; i++) begin
         r = rows[i];
         addr = 8'h10 + 8'(i);
         u_rss_mem_model.mem[addr] = r.m;
         op_i = rss_pkg::rss_op_type'(r.op);
         to_acc_i = r.ta;
         bit_sel_i = r.bs;
         exec_i = 1'h1;
         @(negedge clk_i);
         exec_i = 1'h0;
         check("acc", acc_o, r.acc);
         check("flags", {4'h0, ovf_o, zero_o, nib_o, carry_o}, {4'h0, r.fl});
         check("write strobe", {7'h00, mem_we_o}, {7'h00, r.we});
         if (r.we) begin
            check("write data", mem_wdata_o, r.wd);
            check("write addr", mem_addr_o, addr);
         end
         check("skip", {6'h00, discard_fetch_o, busy_o}, {6'h00, r.sk, r.sk});
         check("done", {7'h00, done_o}, 8'h01);
         @(negedge clk_i);
         check("memory", u_rss_mem_model.mem[addr], r.we ? r.wd : r.m);
      end
      // a request held through the dummy cycle must be ignored, then taken right after
      u_rss_mem_model.mem[8'h30] = 8'h01;
      u_rss_mem_model.mem[8'h31] = 8'h5a;
      addr = 8'h30;
      op_i = rss_pkg::RSS_OP_DEC_SKIP_NIL;
      to_acc_i = 1'h1;
      exec_i = 1'h1;
      @(negedge clk_i);
      check("dummy cycle", {5'h00, discard_fetch_o, busy_o, done_o}, 8'h07);
      addr = 8'h31;
      op_i = rss_pkg::RSS_OP_SET_BYTE;
      to_acc_i = 1'h0;
      @(negedge clk_i);
      check("ignored take", {6'h00, done_o, mem_we_o}, 8'h00);
      @(negedge clk_i);
      exec_i = 1'h0;
      check("late take", {6'h00, done_o, mem_we_o}, 8'h03);
      check("late data", mem_wdata_o, rss_pkg::ALL_ONES);
      @(negedge clk_i);
      check("late memory", u_rss_mem_model.mem[8'h31], 8'hff);
      check("acc kept memory", u_rss_mem_model.mem[8'h30], 8'h01);
      // load the accumulator and leave every pulse high, so the second reset has real work to undo
      u_rss_mem_model.mem[8'h32] = 8'h41;
      u_rss_mem_model.mem[8'h33] = 8'h01;
      addr = 8'h32;
      op_i = rss_pkg::RSS_OP_INC_SKIP_NIL;
      to_acc_i = 1'h1;
      exec_i = 1'h1;
      @(negedge clk_i);
      check("inc acc", acc_o, 8'h42);
      addr = 8'h33;
      op_i = rss_pkg::RSS_OP_DEC_SKIP_NIL;
      to_acc_i = 1'h0;
      @(negedge clk_i);
      exec_i = 1'h0;
      check("pre-reset pulses", {4'h0, mem_we_o, discard_fetch_o, busy_o, done_o}, 8'h0f);
      rstn_i = 1'h0;
      repeat (2) @(negedge clk_i);
      check("reset acc", acc_o, 8'h00);
      check("reset flags", {4'h0, ovf_o, zero_o, nib_o, carry_o}, 8'h00);
      check("reset pulses", {4'h0, mem_we_o, discard_fetch_o, busy_o, done_o}, 8'h00);
      check("reset addr", mem_addr_o, 8'h00);
      check("reset data", mem_wdata_o, 8'h00);
      rstn_i = 1'h1;
      // the first request may arrive right at the first edge after release
      u_rss_mem_model.mem[8'h34] = 8'h10;
      addr = 8'h34;
      op_i = rss_pkg::RSS_OP_SET_BIT;
      bit_sel_i = 3'h0;
      exec_i = 1'h1;
      @(negedge clk_i);
      exec_i = 1'h0;
      check("first take", {6'h00, done_o, mem_we_o}, 8'h03);
      check("first data", mem_wdata_o, 8'h11);
      @(negedge clk_i);
      check("first memory", u_rss_mem_model.mem[8'h34], 8'h11);
      give_verdict();
   end
endmodule : tb_rss_alu
